//--- hdl/ibs_pkg.sv
// ============================================================
// shared constants and carriers for the bus status flag block
package ibs_pkg;

    // ============================================================
    // register map, byte addresses on the wishbone slave
    localparam logic [7:0] IBS_OFS_STATUS = 8'h00;
    localparam logic [7:0] IBS_OFS_CTRL = 8'h04;

    // bus_status_flags field positions
    localparam int IBS_BIT_TX = 9;
    localparam int IBS_BIT_ACK = 8;
    localparam int IBS_BIT_BUSY = 6;
    localparam int IBS_BIT_START = 5;
    localparam int IBS_BIT_STOP = 4;
    localparam int IBS_STATUS_W = 16;

    // control register field positions
    localparam int IBS_CTL_ENABLE = 0;
    localparam int IBS_CTL_INIT_SEL = 1;
    localparam int IBS_CTL_START_REQ = 2;
    localparam int IBS_CTL_EXIT = 3;
    localparam int IBS_CTL_WAIT_REL = 4;

    // reset values
    localparam logic IBS_RST_ENABLE = 1'b0;
    localparam logic IBS_RST_INIT_SEL = 1'b1;
    localparam logic IBS_RST_BUSY = 1'b0; // consistent with init select of 1

    // ============================================================
    // serial bit positions within a byte, counted in scl falling edges
    localparam logic [3:0] IBS_RW_RISE_CNT = 4'h7;  // 8th rise samples the direction bit
    localparam logic [3:0] IBS_ACK_RISE_CNT = 4'h8; // 9th rise samples the acknowledge bit
    localparam logic [3:0] IBS_FALL_8TH = 4'h8;
    localparam logic [3:0] IBS_FALL_9TH = 4'h9;
    localparam int IBS_SYNC_DEPTH = 3;

    // ============================================================
    // bus events passed from the link domain to the system domain
    typedef struct packed {
        logic rise_post_addr; // scl rise once the address byte is done
        logic ninth_fall;     // 9th scl falling edge, wait point
        logic ack_low;        // 9th fall with a low acknowledge bit
        logic addr8_rw1;      // 8th fall of an address byte with direction 1
        logic first_fall;     // first scl fall after a start
        logic scl_rise;
        logic stop;
        logic start;
    } ibs_evt_t;

    localparam int IBS_EVT_N = $bits(ibs_evt_t);

    // software controls held in the system domain
    typedef struct packed {
        logic start_pend;
        logic init_sel;
        logic enable;
    } ibs_ctrl_t;

endpackage : ibs_pkg

//--- hdl/ibs_status.sv
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module ibs_status
    import ibs_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic LINK_CLK_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic MASTER_I,
    input wire logic ADDR_MATCH_I,
    input wire logic ARB_LOST_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [IBS_STATUS_W-1:0] BUS_STATUS_O
);

    // ============================================================
    // link domain: reset release
    logic [1:0] link_rst_q;
    logic link_nrst;

    // assert at once, release two link edges later; NRST_I is released on a
    // system edge, so no link flop may see that release arrive mid-edge
    always_ff @(posedge LINK_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            link_rst_q <= 2'b00;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b1};
        end
    end

    assign link_nrst = link_rst_q[1];

    // ============================================================
    // link domain: pin synchronisers
    logic [IBS_SYNC_DEPTH-1:0] scl_s;
    logic [IBS_SYNC_DEPTH-1:0] sda_s;
    logic scl_q;
    logic sda_q;
    logic scl_new;
    logic sda_new;

    // three stages; a level counts once the 2nd and 3rd stage agree
    always_ff @(posedge LINK_CLK_I or negedge link_nrst) begin
        if (!link_nrst) begin
            scl_s <= '1;
            sda_s <= '1;
        end else begin
            scl_s <= {scl_s[1:0], SCL_I};
            sda_s <= {sda_s[1:0], SDA_I};
        end
    end

    // filtered levels; idle bus reads high through the pull-ups
    // a one-sample glitch never reaches the filtered level, at the cost of
    // one extra link cycle of latency
    always_comb begin
        scl_new = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_q;
        sda_new = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
    end

    always_ff @(posedge LINK_CLK_I or negedge link_nrst) begin
        if (!link_nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_new;
            sda_q <= sda_new;
        end
    end

    // ============================================================
    // link domain: condition and bit position tracking
    logic scl_rise;
    logic scl_fall;
    logic cond_start;
    logic cond_stop;
    logic [3:0] fall_cnt;
    logic first_pend;
    logic addr_phase;
    logic rw_bit;
    logic ack_bit;
    ibs_evt_t evt;

    // start and stop only count while scl stays high across the sda edge
    always_comb begin
        scl_rise = scl_new & ~scl_q;
        scl_fall = ~scl_new & scl_q;
        cond_start = scl_q & scl_new & sda_q & ~sda_new;
        cond_stop = scl_q & scl_new & ~sda_q & sda_new;
    end

    // falls are counted per byte; the fall that ends a start is not a bit
    // a stop mid-byte restarts the count, so a cut frame leaves no stale position
    always_ff @(posedge LINK_CLK_I or negedge link_nrst) begin
        if (!link_nrst) begin
            fall_cnt <= 4'h0;
            first_pend <= 1'b0;
        end else if (cond_start) begin
            fall_cnt <= 4'h0;
            first_pend <= 1'b1;
        end else if (cond_stop) begin
            fall_cnt <= 4'h0;
            first_pend <= 1'b0;
        end else if (scl_fall) begin
            if (first_pend) begin
                first_pend <= 1'b0;
            end else if (fall_cnt == IBS_FALL_9TH) begin
                fall_cnt <= 4'h1;
            end else begin
                fall_cnt <= fall_cnt + 4'h1;
            end
        end
    end

    // address phase runs from start to the 9th fall of the first byte
    always_ff @(posedge LINK_CLK_I or negedge link_nrst) begin
        if (!link_nrst) begin
            addr_phase <= 1'b0;
        end else if (cond_start) begin
            addr_phase <= 1'b1;
        end else if (cond_stop) begin
            addr_phase <= 1'b0;
        end else if (scl_fall && !first_pend && fall_cnt == IBS_FALL_8TH) begin
            addr_phase <= 1'b0;
        end
    end

    // direction and acknowledge bits are sampled on their scl rise
    always_ff @(posedge LINK_CLK_I or negedge link_nrst) begin
        if (!link_nrst) begin
            rw_bit <= 1'b0;
            ack_bit <= 1'b1;
        end else if (scl_rise) begin
            if (addr_phase && fall_cnt == IBS_RW_RISE_CNT) begin
                rw_bit <= sda_q;
            end
            if (fall_cnt == IBS_ACK_RISE_CNT) begin
                ack_bit <= sda_q;
            end
        end
    end

    // single-cycle events in the link domain
    always_comb begin
        evt = '0;
        evt.start = cond_start;
        evt.stop = cond_stop;
        evt.scl_rise = scl_rise;
        evt.first_fall = scl_fall & first_pend;
        evt.addr8_rw1 = scl_fall & ~first_pend & addr_phase & rw_bit
                        & (fall_cnt == IBS_RW_RISE_CNT);
        evt.ack_low = scl_fall & ~first_pend & ~ack_bit & (fall_cnt == IBS_ACK_RISE_CNT);
        evt.ninth_fall = scl_fall & ~first_pend & (fall_cnt == IBS_ACK_RISE_CNT);
        evt.rise_post_addr = scl_rise & ~addr_phase;
    end

    // ============================================================
    // crossing: one toggle per event, three flops on the system side
    logic [IBS_EVT_N-1:0] evt_vec;
    logic [IBS_EVT_N-1:0] sys_ev;
    ibs_evt_t ev;

    assign evt_vec = evt;

    // events arrive at most once per link cycle, far slower than the system clock
    // limitation: the link clock must stay well below the system clock, or a
    // toggle could come and go between two system samples
    genvar gi;
    generate
        for (gi = 0; gi < IBS_EVT_N; gi++) begin : g_cross
            logic tog_b;
            logic [IBS_SYNC_DEPTH-1:0] tsync;
            always_ff @(posedge LINK_CLK_I or negedge link_nrst) begin
                if (!link_nrst) begin
                    tog_b <= 1'b0;
                end else begin
                    tog_b <= tog_b ^ evt_vec[gi];
                end
            end
            always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
                if (!NRST_I) begin
                    tsync <= '0;
                end else begin
                    tsync <= {tsync[1:0], tog_b};
                end
            end
            assign sys_ev[gi] = tsync[1] ^ tsync[2];
        end
    endgenerate

    assign ev = sys_ev;

    // ============================================================
    // system domain: wishbone slave
    logic wb_req;
    logic wr_ctrl;
    logic wr_exit;
    logic wr_wait_rel;
    logic wr_enable;
    ibs_ctrl_t ctrl;
    logic [IBS_STATUS_W-1:0] status;

    // writes take effect on the edge that raises ack; only byte lane 0 holds bits
    always_comb begin
        wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
        wr_ctrl = wb_req & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == IBS_OFS_CTRL);
        wr_exit = wr_ctrl & WB_DAT_I[IBS_CTL_EXIT];
        wr_wait_rel = wr_ctrl & WB_DAT_I[IBS_CTL_WAIT_REL];
        wr_enable = wr_ctrl & WB_DAT_I[IBS_CTL_ENABLE];
    end

    // ack follows one cycle after the strobe and drops the next cycle
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_req;
        end
    end

    // read data; unmapped addresses answer with zero; reads change nothing
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            WB_DAT_O <= '0;
        end else if (wb_req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                IBS_OFS_STATUS: WB_DAT_O <= {16'h0000, status};
                IBS_OFS_CTRL: WB_DAT_O <= {29'h0, ctrl.start_pend, ctrl.init_sel, ctrl.enable};
                default: WB_DAT_O <= '0;
            endcase
        end
    end

    // control bits; a pending start request is consumed by the next start
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl.enable <= IBS_RST_ENABLE;
            ctrl.init_sel <= IBS_RST_INIT_SEL;
            ctrl.start_pend <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl.enable <= WB_DAT_I[IBS_CTL_ENABLE];
                ctrl.init_sel <= WB_DAT_I[IBS_CTL_INIT_SEL];
            end
            if (wr_ctrl && WB_DAT_I[IBS_CTL_START_REQ]) begin
                ctrl.start_pend <= 1'b1;
            end else if (ev.start || wr_exit) begin
                ctrl.start_pend <= 1'b0;
            end
        end
    end

    // ============================================================
    // system domain: status flags; every set wins over a clear
    logic tx_flag;
    logic ack_flag;
    logic busy_flag;
    logic start_flag;
    logic stop_flag;
    logic in_wait9;
    logic tx_set;
    logic tx_clr;

    // wait after the 9th fall lasts until scl rises again, a wait release write, or the frame ends
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            in_wait9 <= 1'b0;
        end else if (ev.ninth_fall) begin
            in_wait9 <= 1'b1;
        end else if (ev.scl_rise || ev.stop || ev.start || wr_wait_rel) begin
            in_wait9 <= 1'b0;
        end
    end

    // role-dependent set and clear terms for transmit status
    // ADDR_MATCH_I is read as the 8th-fall event lands, a few link cycles plus two system cycles
    // after the wire edge; the address logic must hold it until the ack bit
    always_comb begin
        tx_set = (MASTER_I & ev.start & ctrl.start_pend)
               | (~MASTER_I & ADDR_MATCH_I & ev.addr8_rw1);
        tx_clr = wr_exit | ev.stop | (wr_wait_rel & in_wait9)
               | (MASTER_I & (ev.addr8_rw1 | ARB_LOST_I))
               | (~MASTER_I & ev.start);
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            tx_flag <= 1'b0;
        end else begin
            tx_flag <= tx_set | (tx_flag & ~tx_clr);
        end
    end

    // acknowledge flag, independent of any interrupt path
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ack_flag <= 1'b0;
        end else begin
            ack_flag <= (ev.ack_low & (MASTER_I | ADDR_MATCH_I))
                      | (ack_flag & ~(ev.scl_rise | wr_exit));
        end
    end

    // bus busy; reset value 0 is the inverse of the init select reset value 1
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_flag <= IBS_RST_BUSY;
        end else begin
            busy_flag <= ev.start | (wr_enable & ~WB_DAT_I[IBS_CTL_INIT_SEL])
                       | (busy_flag & ~ev.stop);
        end
    end

    // start seen and stop seen follow every frame on the wire
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            start_flag <= 1'b0;
            stop_flag <= 1'b0;
        end else begin
            start_flag <= ev.start
                        | (start_flag & ~(wr_exit | ev.stop | ev.rise_post_addr));
            stop_flag <= ev.stop | (stop_flag & ~ev.first_fall);
        end
    end

    // status word; software has no write path to it
    // spare bits read as zero so software may test a flag with a plain compare
    always_comb begin
        status = '0;
        status[IBS_BIT_TX] = tx_flag;
        status[IBS_BIT_ACK] = ack_flag;
        status[IBS_BIT_BUSY] = busy_flag;
        status[IBS_BIT_START] = start_flag;
        status[IBS_BIT_STOP] = stop_flag;
    end

    // registered copy for the rest of the unit
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            BUS_STATUS_O <= '0;
        end else begin
            BUS_STATUS_O <= status;
        end
    end

endmodule : ibs_status

`default_nettype wire

//--- sim/ibs_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checks for the status flag block
module ibs_status_chk
    import ibs_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic MASTER_I,
    input wire logic ARB_LOST_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic [IBS_STATUS_W-1:0] BUS_STATUS_O
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // line events reach the flags through the link sampler within 90 cycles
    a_bus_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered next cycle");
    a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack longer than one cycle");
    a_spare_zero: assert property ((BUS_STATUS_O & 16'hFC8F) == 16'h0000)
        else $error("unused status bit set");
    a_start_flags: assert property (
        SCL_I && $fell(SDA_I) |-> ##[1:90]
            (BUS_STATUS_O[IBS_BIT_START] && BUS_STATUS_O[IBS_BIT_BUSY]))
        else $error("start not flagged");
    a_stop_flags: assert property (
        SCL_I && $rose(SDA_I) |-> ##[1:90] (BUS_STATUS_O[IBS_BIT_STOP]
            && !BUS_STATUS_O[IBS_BIT_BUSY] && !BUS_STATUS_O[IBS_BIT_START]))
        else $error("stop not flagged");
    a_ack_drop: assert property ($rose(SCL_I) |-> ##[1:90] !BUS_STATUS_O[8])
        else $error("ack flag kept over clock rise");
    a_stop_seen_clr: assert property (
        $fell(SCL_I) && BUS_STATUS_O[IBS_BIT_START] |-> ##[1:90] !BUS_STATUS_O[IBS_BIT_STOP])
        else $error("stop flag kept after first fall");
    a_arb_tx_clr: assert property (MASTER_I && ARB_LOST_I |-> ##[1:4] !BUS_STATUS_O[9])
        else $error("transmit flag kept after arbitration loss");
endmodule : ibs_status_chk

bind ibs_status ibs_status_chk i_chk (
    .SYS_CLK_I, .NRST_I, .SCL_I, .SDA_I, .MASTER_I, .ARB_LOST_I,
    .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .BUS_STATUS_O
);
`default_nettype wire

//--- sim/ibs_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// far-side device on the two open-drain lines
module ibs_bus_model (
    input wire logic link_clk_i,
    output var logic scl_o,
    output var logic sda_o
);
    // released lines rest at the pull-up level
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // each level is held long enough for the three-stage sampler to agree
    task automatic put(input logic scl, input logic sda, input int hold);
        @(posedge link_clk_i);
        scl_o <= scl;
        sda_o <= sda;
        repeat (hold) @(posedge link_clk_i);
    endtask : put
endmodule : ibs_bus_model
`default_nettype wire

//--- sim/ibs_status_test.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench for the status flag block
module ibs_status_test
    import ibs_pkg::*;
;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic master = 1'b0;
    logic addr_match = 1'b0;
    logic arb_lost = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd_dat;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [15:0] status;
    wire logic scl;
    wire logic sda;
    int err_total = 0;
    int num_checks = 0;
    int hold = 6;

    // two unrelated clocks; link gets two edges inside reset
    always #5 sys_clk = ~sys_clk;
    initial begin
        #23 link_clk = 1'b1;
        forever #80 link_clk = ~link_clk;
    end

    ibs_bus_model i_bus (.link_clk_i(link_clk), .scl_o(scl), .sda_o(sda));
    ibs_status i_dut (
        .SYS_CLK_I(sys_clk), .NRST_I(nrst), .LINK_CLK_I(link_clk), .SCL_I(scl),
        .SDA_I(sda), .MASTER_I(master), .ADDR_MATCH_I(addr_match), .ARB_LOST_I(arb_lost),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat), .WB_DAT_O(wb_dat), .WB_ACK_O(wb_ack), .BUS_STATUS_O(status)
    );

    // ============================================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one classic cycle; the answer is waited for, never assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge sys_clk);
        end while (wb_ack !== 1'b1);
        rd_dat = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb
    task automatic expect_status(input logic [15:0] exp);
        wb(1'b0, IBS_OFS_STATUS, 32'h0);
        check(rd_dat[15:0], exp);
        check(status, exp);
    endtask : expect_status
    task automatic bit_out(input logic b);
        i_bus.put(1'b0, b, hold);
        i_bus.put(1'b1, b, hold);
        i_bus.put(1'b0, b, hold);
    endtask : bit_out
    // data moves only while the clock is low, so no false start or stop
    task automatic start_cond();
        i_bus.put(1'b0, 1'b1, hold);
        i_bus.put(1'b1, 1'b1, hold);
        i_bus.put(1'b1, 1'b0, hold);
        i_bus.put(1'b0, 1'b0, hold);
    endtask : start_cond
    task automatic stop_cond();
        i_bus.put(1'b0, 1'b1, hold);
        i_bus.put(1'b0, 1'b0, hold);
        i_bus.put(1'b1, 1'b0, hold);
        i_bus.put(1'b1, 1'b1, hold);
    endtask : stop_cond
    task automatic addr_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
    endtask : addr_byte

    // ============================================================
    // scenarios
    task automatic t_idle();
        expect_status(16'h0000);
        wb(1'b1, IBS_OFS_STATUS, 32'hFFFF);
        expect_status(16'h0000);
        wb(1'b0, 8'h08, 32'h0);
        check(rd_dat[15:0], 16'h0000);
        wb(1'b1, IBS_OFS_CTRL, 32'h01);
        wb(1'b0, IBS_OFS_CTRL, 32'h0);
        check(rd_dat[15:0], 16'h0001);
        expect_status(16'h0040);
        stop_cond();
        expect_status(16'h0010);
        $display("idle test done");
    endtask : t_idle
    task automatic t_master();
        master <= 1'b1;
        wb(1'b1, IBS_OFS_CTRL, 32'h07);
        start_cond();
        expect_status(16'h0260);
        addr_byte(8'hA5);
        expect_status(16'h0060);
        bit_out(1'b0);
        expect_status(16'h0160);
        bit_out(1'b1);
        expect_status(16'h0040);
        stop_cond();
        expect_status(16'h0010);
        $display("master test done");
    endtask : t_master
    // slow far side: levels held twice as long
    task automatic t_slave();
        master <= 1'b0;
        addr_match <= 1'b1;
        hold = 12;
        start_cond();
        expect_status(16'h0060);
        addr_byte(8'hA5);
        expect_status(16'h0260);
        bit_out(1'b0);
        expect_status(16'h0360);
        start_cond();
        expect_status(16'h0060);
        addr_byte(8'hA5);
        bit_out(1'b0);
        wb(1'b1, IBS_OFS_CTRL, 32'h13);
        expect_status(16'h0160);
        wb(1'b1, IBS_OFS_CTRL, 32'h0B);
        expect_status(16'h0040);
        stop_cond();
        expect_status(16'h0010);
        hold = 6;
        $display("slave test done");
    endtask : t_slave
    task automatic t_arb();
        master <= 1'b1;
        addr_match <= 1'b0;
        wb(1'b1, IBS_OFS_CTRL, 32'h07);
        start_cond();
        expect_status(16'h0260);
        arb_lost <= 1'b1;
        @(posedge sys_clk);
        arb_lost <= 1'b0;
        expect_status(16'h0060);
        stop_cond();
        expect_status(16'h0010);
        $display("arbitration test done");
    endtask : t_arb
    // transmit status cleared by stop and by exit; a frame nobody joins
    task automatic t_clear();
        master <= 1'b1;
        addr_match <= 1'b0;
        wb(1'b1, IBS_OFS_CTRL, 32'h07);
        wb(1'b0, IBS_OFS_CTRL, 32'h0);
        check(rd_dat[15:0], 16'h0007);
        start_cond();
        wb(1'b0, IBS_OFS_CTRL, 32'h0);
        check(rd_dat[15:0], 16'h0003);
        addr_byte(8'hA4);
        expect_status(16'h0260);
        stop_cond();
        expect_status(16'h0010);
        wb(1'b1, IBS_OFS_CTRL, 32'h07);
        start_cond();
        expect_status(16'h0260);
        wb(1'b1, IBS_OFS_CTRL, 32'h0B);
        expect_status(16'h0040);
        stop_cond();
        master <= 1'b0;
        start_cond();
        addr_byte(8'hA5);
        bit_out(1'b0);
        expect_status(16'h0060);
        stop_cond();
        expect_status(16'h0010);
        $display("clear test done");
    endtask : t_clear

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        t_idle();
        t_master();
        t_slave();
        t_arb();
        t_clear();
        conclude();
    end
    // about twice the expected run time
    initial begin
        #600us;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule : ibs_status_test
`default_nettype wire
